// file: rtl/boot_sel_pkg.sv
package boot_sel_pkg;

    // Boot-select code layout
    localparam int          BOOT_CODE_W       = 3;
    localparam int          BOOT_PIN_HIGH_BIT = 2;
    localparam logic [2:0]  CODE_NO_BOOT      = 3'h0;
    localparam logic [2:0]  CODE_SER_MASTER   = 3'h1;
    localparam logic [2:0]  CODE_SER_SLAVE    = 3'h2;
    localparam logic [2:0]  CODE_UART_SLAVE   = 3'h3;
    localparam logic [2:0]  CODE_RESERVED_A   = 3'h4;
    localparam logic [2:0]  CODE_RESERVED_B   = 3'h5;
    localparam logic [2:0]  CODE_LINK_SLAVE   = 3'h6;

    // Reset value of the boot-mode field in the reset configuration
    localparam logic [2:0]  BOOT_FIELD_RESET  = 3'h0;

    // PLL lock time and its cycle count at the 50 MHz mclk
    localparam int          MCLK_PERIOD_NS    = 20;
    localparam int          PLL_LOCK_TIME_NS  = 40960;
    localparam int          PLL_LOCK_CYCLES   =
        (PLL_LOCK_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    // Core arrangement
    localparam int          NUM_CORES_DEFAULT = 3;
    localparam int          BOOT_CORE_DEFAULT = 0;

    // Decoded boot modes
    typedef enum logic [2:0]
    {
        MODE_NO_BOOT,
        MODE_SER_MASTER,
        MODE_SER_SLAVE,
        MODE_UART_SLAVE,
        MODE_RESERVED,
        MODE_LINK_SLAVE
    } boot_mode_type;

    // Enables toward the boot interfaces
    typedef struct packed
    {
        logic ser_master_fetch;
        logic ser_slave_accept;
        logic uart_slave_accept;
        logic link_slave_accept;
    } boot_port_type;

    // Code to mode; link boot needs the third pin to be bonded out
    function automatic boot_mode_type decode_mode(input logic [2:0] code,
                                                  input logic       third_pin);
        boot_mode_type m;
        m = MODE_RESERVED;
        unique case (code)
            CODE_NO_BOOT:     m = MODE_NO_BOOT;
            CODE_SER_MASTER:  m = MODE_SER_MASTER;
            CODE_SER_SLAVE:   m = MODE_SER_SLAVE;
            CODE_UART_SLAVE:  m = MODE_UART_SLAVE;
            CODE_LINK_SLAVE:  m = third_pin ? MODE_LINK_SLAVE : MODE_RESERVED;
            default:          m = MODE_RESERVED;
        endcase
        return m;
    endfunction

    // Port enables that belong to a mode
    function automatic boot_port_type mode_ports(input boot_mode_type m);
        boot_port_type p;
        p = '0;
        p.ser_master_fetch  = (m == MODE_SER_MASTER);
        p.ser_slave_accept  = (m == MODE_SER_SLAVE);
        p.uart_slave_accept = (m == MODE_UART_SLAVE);
        p.link_slave_accept = (m == MODE_LINK_SLAVE);
        return p;
    endfunction

endpackage

// file: rtl/pin_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync2
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_r;

    initial
    begin
        if (WIDTH < 1)
            $error("pin_sync2 needs WIDTH of at least one");
    end

    // First stage feeds only the second stage
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1_r <= async_in;
            sync_out <= stage1_r;
        end
    end

endmodule // pin_sync2

`default_nettype wire

// file: rtl/reset_boot_mode_select.sv
// Behaviour
// - Boot-select pins are captured at every power-on and software reset and pick the mode.
// - The captured code is held in the boot-mode field of the reset configuration.
// - Code 000 loads nothing and code 001 boots as master from serial memory on SPI two.
// - Code 010 boots as slave on SPI two and code 011 as slave on UART zero.
// - Codes 100 and 101 select no boot source and code 110 boots as slave on link zero.
// - In master mode the device starts the transfers and fetches the image itself.
// - In slave mode the device only accepts the image that the host drives in.
// - One chosen core runs the boot load while all other cores wait.
// - The rising edge of the hardware reset input starts the PLL lock counter.
// - Link zero slave boot exists only on the variant that bonds out the third pin.
`timescale 1ns/1ps
`default_nettype none

module reset_boot_mode_select
    import boot_sel_pkg::*;
#(
    parameter int NUM_CORES       = NUM_CORES_DEFAULT,
    parameter int BOOT_CORE       = BOOT_CORE_DEFAULT,
    parameter int LOCK_CYCLES     = PLL_LOCK_CYCLES,
    parameter bit THIRD_PIN_BONDED = 1'b1
)
(
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   hardware_reset_input,
    input  wire logic [BOOT_CODE_W-1:0] boot_select_pins,
    input  wire logic                   soft_reset_req,
    input  wire logic                   boot_load_done,
    output var  logic [BOOT_CODE_W-1:0] boot_code_r,
    output var  boot_mode_type          boot_mode_r,
    output var  boot_port_type          boot_port_r,
    output var  logic                   boot_active_r,
    output var  logic                   pll_lock_start_r,
    output var  logic                   pll_locked_r,
    output var  logic [NUM_CORES-1:0]   core_run_r
);

    localparam int CNT_W = $clog2(LOCK_CYCLES + 1);
    localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYCLES - 1);
    localparam logic [CNT_W-1:0] LOCK_FULL = CNT_W'(LOCK_CYCLES);

    typedef enum logic [2:0]
    {
        ST_HELD,
        ST_LOCK,
        ST_SAMPLE,
        ST_LOAD,
        ST_RUN
    } seq_state_type;

    seq_state_type          state_r;
    seq_state_type          state_nxt;
    logic [BOOT_CODE_W:0]   pins_sync;
    logic                   hw_rst_sync;
    logic [BOOT_CODE_W-1:0] code_sync;
    logic                   hw_rst_q_r;
    logic                   hw_rise;
    logic [CNT_W-1:0]       pll_cnt_r;
    logic [BOOT_CODE_W-1:0] code_seen;
    boot_mode_type          load_mode;
    logic [CNT_W-1:0]       lock_seen_r;

    initial
    begin
        if (NUM_CORES < 1 || BOOT_CORE < 0 || BOOT_CORE >= NUM_CORES)
            $error("BOOT_CORE must name one of the NUM_CORES cores");
        if (LOCK_CYCLES < 1)
            $error("LOCK_CYCLES must be at least one");
    end

    // Pins come from outside the clock domain, so both pass two flops
    pin_sync2
    #(
        .WIDTH    (BOOT_CODE_W + 1)
    )
    u_pin_sync
    (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .async_in ({hardware_reset_input, boot_select_pins}),
        .sync_out (pins_sync)
    );

    assign hw_rst_sync = pins_sync[BOOT_CODE_W];
    assign code_sync   = pins_sync[BOOT_CODE_W-1:0];

    // Without the third pin its input reads low, so 110 cannot be reached
    assign code_seen = THIRD_PIN_BONDED ? code_sync
                     : {1'b0, code_sync[BOOT_PIN_HIGH_BIT-1:0]};

    // Edge detect on the synchronised hardware reset level
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            hw_rst_q_r <= 1'b0;
        else
            hw_rst_q_r <= hw_rst_sync;
    end

    assign hw_rise = hw_rst_sync && !hw_rst_q_r;

    // Sequencer: hold, lock, sample, load, run
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_HELD:
                if (hw_rise)
                    state_nxt = ST_LOCK;
            ST_LOCK:
                if (pll_cnt_r == LOCK_LAST)
                    state_nxt = ST_SAMPLE;
            ST_SAMPLE:
                state_nxt = ST_LOAD;
            ST_LOAD:
                if (soft_reset_req)
                    state_nxt = ST_SAMPLE;
                else if (boot_load_done || boot_mode_r == MODE_NO_BOOT
                         || boot_mode_r == MODE_RESERVED)
                    state_nxt = ST_RUN;
            ST_RUN:
                if (soft_reset_req)
                    state_nxt = ST_SAMPLE;
        endcase
        // Dropping the hardware reset sends the sequencer back to hold from any state
        if (!hw_rst_sync)
            state_nxt = ST_HELD;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            state_r <= ST_HELD;
        else
            state_r <= state_nxt;
    end

    // PLL lock counter starts on the rising hardware reset edge
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            pll_cnt_r <= '0;
        else if (state_r == ST_LOCK)
            pll_cnt_r <= pll_cnt_r + CNT_W'(1);
        else
            pll_cnt_r <= '0;
    end

    // One-cycle start pulse and lock level for the clock unit
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pll_lock_start_r <= 1'b0;
            pll_locked_r     <= 1'b0;
        end
        else
        begin
            pll_lock_start_r <= (state_r == ST_HELD) && hw_rise;
            if (!hw_rst_sync)
                pll_locked_r <= 1'b0;
            else if (state_r == ST_LOCK && pll_cnt_r == LOCK_LAST)
                pll_locked_r <= 1'b1;
        end
    end

    // Capture happens only in the sample state; pins are ignored otherwise
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            boot_code_r <= BOOT_FIELD_RESET;
            boot_mode_r <= MODE_NO_BOOT;
        end
        else if (state_r == ST_SAMPLE)
        begin
            boot_code_r <= code_seen;
            boot_mode_r <= decode_mode(code_seen, THIRD_PIN_BONDED);
        end
    end

    // The mode being captured drives the enables from the first load cycle,
    // so a stale mode from an earlier boot never opens an interface
    assign load_mode = (state_r == ST_SAMPLE) ? decode_mode(code_seen, THIRD_PIN_BONDED)
                                              : boot_mode_r;

    // Interface enables live only while the boot core is loading
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            boot_port_r   <= '0;
            boot_active_r <= 1'b0;
        end
        else if (state_nxt == ST_LOAD)
        begin
            boot_port_r   <= mode_ports(load_mode);
            boot_active_r <= 1'b1;
        end
        else
        begin
            boot_port_r   <= '0;
            boot_active_r <= 1'b0;
        end
    end

    // Boot core runs from load onward; the others wait for the run state
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            core_run_r <= '0;
        else
        begin
            for (int i = 0; i < NUM_CORES; i++)
            begin
                if (i == BOOT_CORE)
                    core_run_r[i] <= (state_nxt == ST_LOAD) || (state_nxt == ST_RUN);
                else
                    core_run_r[i] <= (state_nxt == ST_RUN);
            end
        end
    end

    // The reset source keeps hardware reset low until supplies are valid;
    // nothing here can check that, so lock time is counted only from release.

    // Lock-state cycles counted apart from the sequencer, for the lock-time check
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            lock_seen_r <= '0;
        else if (state_r == ST_LOCK)
            lock_seen_r <= lock_seen_r + CNT_W'(1);
        else
            lock_seen_r <= '0;
    end

    sequence s_rise;
        state_r == ST_HELD && hw_rise;
    endsequence

    sequence s_sample;
        state_r == ST_SAMPLE && hw_rst_sync;
    endsequence

    a_pll_start_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
        s_rise |=> pll_lock_start_r ##1 !pll_lock_start_r)
        else $error("PLL start pulse missing after hardware reset rise");

    a_pll_lock_time: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(state_r == ST_LOCK) |->
            (!pll_locked_r throughout (state_r == ST_LOCK) [*1]))
        else $error("PLL reported locked before count ran");

    a_capture_code: assert property (@(posedge mclk) disable iff (!reset_n)
        s_sample |=> boot_code_r == $past(code_seen))
        else $error("Reset configuration field does not hold sampled code");

    a_code_stable: assert property (@(posedge mclk) disable iff (!reset_n)
        $past(state_r) != ST_SAMPLE |-> $stable(boot_code_r))
        else $error("Boot code changed outside a sample");

    a_mode_decode: assert property (@(posedge mclk) disable iff (!reset_n)
        s_sample |=> boot_mode_r == decode_mode($past(code_seen), THIRD_PIN_BONDED))
        else $error("Boot mode does not match captured code");

    a_reserved_idle: assert property (@(posedge mclk) disable iff (!reset_n)
        boot_mode_r == MODE_RESERVED || boot_mode_r == MODE_NO_BOOT |-> boot_port_r == '0)
        else $error("Reserved or no-boot code enabled an interface");

    a_link_variant: assert property (@(posedge mclk) disable iff (!reset_n)
        !THIRD_PIN_BONDED |-> boot_mode_r != MODE_LINK_SLAVE && !boot_port_r.link_slave_accept)
        else $error("Link boot offered without third pin");

    a_one_port: assert property (@(posedge mclk) disable iff (!reset_n)
        $onehot0(boot_port_r) && (boot_port_r == '0 || boot_active_r))
        else $error("More than one boot interface enabled");

    a_others_wait: assert property (@(posedge mclk) disable iff (!reset_n)
        boot_active_r |-> core_run_r[BOOT_CORE] && $countones(core_run_r) == 1)
        else $error("Non-boot core ran during boot load");

    a_soft_resample: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_r == ST_RUN && soft_reset_req && hw_rst_sync) |=> s_sample ##1 state_r == ST_LOAD)
        else $error("Software reset did not resample the boot pins");

    a_lock_length: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(pll_locked_r) |-> lock_seen_r == LOCK_FULL)
        else $error("PLL lock reported after the wrong number of cycles");

    a_port_mode: assert property (@(posedge mclk) disable iff (!reset_n)
        boot_active_r |-> boot_port_r == mode_ports(boot_mode_r))
        else $error("Boot interface enable does not match the captured mode");

    a_hw_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        !hw_rst_sync |=> state_r == ST_HELD && !boot_active_r && core_run_r == '0)
        else $error("Hardware reset low did not hold the cores");

endmodule // reset_boot_mode_select

`default_nettype wire

// file: verification/boot_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module boot_host_model
    import boot_sel_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          reset_n,
    input  wire boot_port_type boot_port_r,
    input  wire logic          slow,
    output var  logic          boot_load_done
);
    int unsigned wait_r;

    // Serves a master fetch or pushes a slave image, then reports the load done
    // The delay is never below two cycles, so the port enables can settle before done
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wait_r         <= 0;
            boot_load_done <= 1'b0;
        end
        else if (boot_load_done)
        begin
            wait_r         <= 0;
            boot_load_done <= 1'b0;
        end
        else if (boot_port_r != '0)
        begin
            wait_r         <= wait_r + 1;
            boot_load_done <= (wait_r == (slow ? 8 : 2));
        end
        else
        begin
            wait_r <= 0;
        end
    end

endmodule // boot_host_model

`default_nettype wire

// file: verification/reset_boot_mode_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module reset_boot_mode_select_tb_top;
    import boot_sel_pkg::*;

    localparam int LOCK = 4;

    logic          mclk;
    logic          reset_n;
    logic          hardware_reset_input;
    logic [2:0]    boot_select_pins;
    logic          soft_reset_req;
    logic          slow;
    logic          boot_load_done;
    logic [2:0]    boot_code_r;
    boot_mode_type boot_mode_r;
    boot_port_type boot_port_r;
    logic          boot_active_r;
    logic          pll_lock_start_r;
    logic          pll_locked_r;
    logic [2:0]    core_run_r;
    logic [2:0]    nb_code;
    boot_mode_type nb_mode;
    int            failures;
    int            checks;

    // Package variant with the third pin bonded out, and one without it
    reset_boot_mode_select #(.LOCK_CYCLES(LOCK)) dut (.mclk(mclk), .reset_n(reset_n),
        .hardware_reset_input(hardware_reset_input), .boot_select_pins(boot_select_pins),
        .soft_reset_req(soft_reset_req), .boot_load_done(boot_load_done),
        .boot_code_r(boot_code_r), .boot_mode_r(boot_mode_r), .boot_port_r(boot_port_r),
        .boot_active_r(boot_active_r), .pll_lock_start_r(pll_lock_start_r),
        .pll_locked_r(pll_locked_r), .core_run_r(core_run_r));
    reset_boot_mode_select #(.LOCK_CYCLES(LOCK), .THIRD_PIN_BONDED(1'b0)) dut_nb (
        .mclk(mclk), .reset_n(reset_n), .hardware_reset_input(hardware_reset_input),
        .boot_select_pins(boot_select_pins), .soft_reset_req(soft_reset_req),
        .boot_load_done(boot_load_done), .boot_code_r(nb_code), .boot_mode_r(nb_mode),
        .boot_port_r(), .boot_active_r(), .pll_lock_start_r(), .pll_locked_r(),
        .core_run_r());
    boot_host_model host (.mclk(mclk), .reset_n(reset_n), .boot_port_r(boot_port_r),
        .slow(slow), .boot_load_done(boot_load_done));

    always #10 mclk = ~mclk;

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Mode and enables expected for each code on the bonded variant
    function automatic boot_mode_type exp_mode(input logic [2:0] c);
        case (c)
            3'h0:    return MODE_NO_BOOT;
            3'h1:    return MODE_SER_MASTER;
            3'h2:    return MODE_SER_SLAVE;
            3'h3:    return MODE_UART_SLAVE;
            3'h6:    return MODE_LINK_SLAVE;
            default: return MODE_RESERVED;
        endcase
    endfunction

    function automatic boot_port_type exp_ports(input logic [2:0] c);
        boot_port_type p;
        p = '0;
        p.ser_master_fetch  = (c == 3'h1);
        p.ser_slave_accept  = (c == 3'h2);
        p.uart_slave_accept = (c == 3'h3);
        p.link_slave_accept = (c == 3'h6);
        return p;
    endfunction

    task automatic wait_load_end();
        int n;
        n = 0;
        while (boot_active_r !== 1'b0 && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        check("cores_run", 8'h07, {5'h0, core_run_r});
        check("ports_off", 8'h00, {4'h0, boot_port_r});
    endtask

    // Full hardware reset cycle with one code on the pins
    task automatic boot_with(input logic [2:0] code, input logic lazy);
        int n;
        @(negedge mclk);
        hardware_reset_input = 1'b0;
        boot_select_pins = code;
        slow = lazy;
        repeat (4) @(negedge mclk);
        check("locked_held", 8'h00, {7'h0, pll_locked_r});
        check("cores_held", 8'h00, {5'h0, core_run_r});
        hardware_reset_input = 1'b1; // released with supplies valid
        n = 0;
        while (pll_lock_start_r !== 1'b1 && n < 10)
        begin
            @(negedge mclk);
            n++;
        end
        check("lock_start", 8'h01, {7'h0, pll_lock_start_r});
        @(negedge mclk);
        check("lock_pulse", 8'h00, {7'h0, pll_lock_start_r});
        n = 1;
        while (pll_locked_r !== 1'b1 && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        check("lock_count", 8'(LOCK), 8'(n));
        @(negedge mclk);
        check("code", {5'h0, code}, {5'h0, boot_code_r});
        check("mode", {5'h0, exp_mode(code)}, {5'h0, boot_mode_r});
        check("boot_core", 8'h01, {5'h0, core_run_r});
        check("first_ports", {4'h0, exp_ports(code)}, {4'h0, boot_port_r});
        @(negedge mclk);
        check("ports", {4'h0, exp_ports(code)}, {4'h0, boot_port_r});
        check("load_active", {7'h0, exp_ports(code) != '0}, {7'h0, boot_active_r});
        check("nb_code", {6'h0, code[1:0]}, {5'h0, nb_code});
        check("nb_mode", {5'h0, exp_mode({1'b0, code[1:0]})}, {5'h0, nb_mode});
        if (code == 3'h6)
        begin
            check("nb_link", 8'h00, 8'(nb_mode == MODE_LINK_SLAVE));
        end
        wait_load_end();
    endtask

    // Pins moving after boot are ignored until a software reset samples them
    task automatic soft_rescan();
        int n;
        boot_with(3'h1, 1'b1);
        boot_select_pins = 3'h3;
        repeat (5) @(negedge mclk);
        check("code_kept", 8'h01, {5'h0, boot_code_r});
        soft_reset_req = 1'b1;
        @(negedge mclk);
        soft_reset_req = 1'b0;
        n = 0;
        while (boot_active_r !== 1'b1 && n < 6)
        begin
            @(negedge mclk);
            n++;
        end
        check("soft_code", 8'h03, {5'h0, boot_code_r});
        @(negedge mclk);
        check("soft_ports", {4'h0, exp_ports(3'h3)}, {4'h0, boot_port_r});
        wait_load_end();
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        reset_n = 1'b0;
        hardware_reset_input = 1'b0;
        boot_select_pins = 3'h0;
        soft_reset_req = 1'b0;
        slow = 1'b0;
        failures = 0;
        checks = 0;
        repeat (10) @(negedge mclk);
        reset_n = 1'b1;
        for (int c = 0; c < 8; c++)
            boot_with(3'(c), c[0]);
        soft_rescan();
        complete_run();
    end

    // Whole run is a few hundred cycles; this span is far beyond it
    initial
    begin
        #200000;
        failures++;
        complete_run();
    end

endmodule // reset_boot_mode_select_tb_top

`default_nettype wire
